// >>> src/sdc_pkg.sv
// Notes on behaviour
// - rj18 internal: 64 Fs, 48 Fs at 384
// - 16-bit internal: 32 Fs, 48 Fs at 384
// - external 18-bit: at least 36 bit clocks
// - external rj16: at least 32 bit clocks
// - data valid and captured on rising edge; edge code 11 captures on falling edge
// - five-bit format register steers the port
// - format register loads variant default at reset
// - code is guard preamble then five bits
// - one code bit per word select fall
// - code 01000000 is ignored as error
// - source holds serial data high while configuring
// - no config writes once external clock mode
// - i2s framing: justify 0, i2s enable 1
// - commit only when preamble is 010
// - internal ratio: 00 gives 32, 10 gives 64
// - external edge: 10 rising, 11 falling
// - justify bit: 0 left, 1 right
// - word length bit: 0 is 18, 1 is 16
// - twos complement msb first, level picks channel
// - four pin rises in a phase: external mode
// - eight equal falls set or clear deemphasis
package sdc_pkg;
  // clocking
  localparam int CLK_NS      = 40;
  localparam int BCLK_NS     = 320;
  localparam int BCLK_DIV    = BCLK_NS / CLK_NS;
  localparam int HALF_BITS   = 32;
  // master ratio classification, in clocks per word select period
  localparam int MR_LIM_LO   = 320;
  localparam int MR_LIM_HI   = 448;
  localparam int MCNT_MAX    = 1023;
  // format register fields
  localparam int F_EDGE_HI   = 4;
  localparam int F_EDGE_LO   = 3;
  localparam int F_JUSTIFY   = 2;
  localparam int F_I2S       = 1;
  localparam int F_WLEN      = 0;
  localparam logic [4:0] FMT_RJ18  = 5'h14;
  localparam logic [4:0] FMT_I2S16 = 5'h03;
  localparam logic [4:0] FMT_RJ16  = 5'h05;
  // configuration code
  localparam logic [2:0] GUARD_CODE = 3'h2;
  localparam logic [7:0] ERROR_CODE = 8'h40;
  localparam int CFG_BITS    = 8;
  localparam int EXT_EDGES   = 4;
  localparam int DEEMPH_FALLS = 8;
  localparam int WORD_LONG   = 18;
  localparam int WORD_SHORT  = 16;
  // source register map
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_CODE   = 4'h1;
  localparam logic [3:0] REG_LEFT   = 4'h2;
  localparam logic [3:0] REG_RIGHT  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int C_RUN       = 0;
  localparam int C_EXT       = 1;
  localparam int C_DEEMPH    = 2;
  localparam int C_RJ        = 3;
  localparam int C_I2S       = 4;
  localparam int C_W16       = 5;
  localparam logic [5:0] CTRL_RESET = 6'h00;

  typedef enum logic [1:0] {SDC_MR_256, SDC_MR_384, SDC_MR_512} sdc_mratio_t;
  typedef enum logic [1:0] {SDC_IDLE, SDC_ARM, SDC_CFG} sdc_src_state_t;
endpackage : sdc_pkg

// >>> src/sdc_link_if.sv
`timescale 1ns/10ps
// three link wires, all driven by the audio source
interface sdc_link_if;
  logic serial_audio_in;
  logic word_select_clock;
  logic emphasis_or_bitclock_pin;
  modport dev (
    input serial_audio_in,
    input word_select_clock,
    input emphasis_or_bitclock_pin
  );
  modport src (
    output serial_audio_in,
    output word_select_clock,
    output emphasis_or_bitclock_pin
  );
endinterface : sdc_link_if

// >>> src/sdc_audio_source.sv
`timescale 1ns/10ps
module sdc_audio_source import sdc_pkg::*; (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  sdc_link_if.src          link,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wr_data_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rd_data_o
);
  logic [5:0]        ctrl;
  logic [7:0]        code;
  logic [17:0]       left;
  logic [17:0]       right;
  logic [2:0]        phase;
  logic [5:0]        idx;
  logic [2:0]        cbit;
  sdc_src_state_t    state;
  logic              ws_out;
  logic              bck_out;
  logic              sd_out;
  logic              pin_out;
  logic              step;

  // bit value for position p of one channel half
  function automatic logic bit_at(input logic [4:0] p, input logic [17:0] s,
                                  input logic rj, input logic i2s,
                                  input logic w16);
    int n;
    int k;
    n = w16 ? WORD_SHORT : WORD_LONG;
    k = -1;
    if (rj) begin
      if (int'(p) >= HALF_BITS - n) k = int'(p) - (HALF_BITS - n);
    end else if (i2s) begin
      if (p != 5'h00 && int'(p) <= n) k = int'(p) - 1;
    end else if (int'(p) < n) begin
      k = int'(p);
    end
    bit_at = (k >= 0) ? s[17 - k] : 1'b0;
  endfunction : bit_at

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ctrl  <= CTRL_RESET;
      code  <= 8'h00;
      left  <= 18'h0_0000;
      right <= 18'h0_0000;
    end else if (wr_i) begin
      unique case (addr_i)
        REG_CTRL:  ctrl  <= wr_data_i[5:0];
        REG_CODE:  code  <= wr_data_i[7:0];
        REG_LEFT:  left  <= wr_data_i[17:0];
        REG_RIGHT: right <= wr_data_i[17:0];
        default: ;
      endcase
    end
  end

  // read data stands in the cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !rd_i) begin
      rd_data_o <= 32'h0000_0000;
    end else begin
      unique case (addr_i)
        REG_CTRL:   rd_data_o <= {26'h000_0000, ctrl};
        REG_CODE:   rd_data_o <= {24'h00_0000, code};
        REG_LEFT:   rd_data_o <= {14'h0000, left};
        REG_RIGHT:  rd_data_o <= {14'h0000, right};
        REG_STATUS: rd_data_o <= {31'h0000_0000, state != SDC_IDLE};
        default:    rd_data_o <= 32'h0000_0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bit and period counters: 64 bit clocks per word select period
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !ctrl[C_RUN]) begin
      phase <= 3'h0;
      idx   <= 6'h00;
    end else if (phase == 3'(BCLK_DIV - 1)) begin
      phase <= 3'h0;
      idx   <= idx + 6'h01;
    end else begin
      phase <= phase + 3'h1;
    end
  end

  // code bit moves at the word select rise, half a period from any fall
  assign step = ctrl[C_RUN] && phase == 3'h0 &&
                idx == (ctrl[C_I2S] ? 6'(HALF_BITS) : 6'h00);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      state <= SDC_IDLE;
      cbit  <= 3'h0;
    end else begin
      unique case (state)
        SDC_IDLE: if (wr_i && addr_i == REG_CODE) state <= SDC_ARM;
        SDC_ARM: if (step) begin
          state <= SDC_CFG;
          cbit  <= 3'h0;
        end
        SDC_CFG: if (step) begin
          if (cbit == 3'(CFG_BITS - 1)) state <= SDC_IDLE;
          else cbit <= cbit + 3'h1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link outputs: word select and data from flops, pin muxed from pin_out and bck_out; data changes while bit clock is low
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ws_out  <= 1'b0;
      bck_out <= 1'b0;
      sd_out  <= 1'b0;
      pin_out <= 1'b1;
    end else begin
      ws_out  <= ctrl[C_RUN] & (idx[5] ~^ ctrl[C_I2S]);
      bck_out <= ctrl[C_RUN] & ctrl[C_EXT] & (state != SDC_CFG) &
                 (phase >= 3'(BCLK_DIV / 2));
      if (state == SDC_CFG) begin
        sd_out  <= 1'b1;
        pin_out <= code[3'(CFG_BITS - 1) - cbit];
      end else begin
        sd_out  <= bit_at(idx[4:0], idx[5] ? right : left, ctrl[C_RJ],
                          ctrl[C_I2S], ctrl[C_W16]);
        pin_out <= ctrl[C_EXT] ? bck_out : ~ctrl[C_DEEMPH];
      end
    end
  end

  assign link.word_select_clock        = ws_out;
  assign link.serial_audio_in          = sd_out;
  assign link.emphasis_or_bitclock_pin = (state == SDC_CFG || !ctrl[C_EXT])
                                         ? pin_out : bck_out;
endmodule : sdc_audio_source

// >>> src/sdc_dac_port.sv
`timescale 1ns/10ps
module sdc_dac_port import sdc_pkg::*; #(
  parameter logic [4:0] DEFAULT_FORMAT = FMT_RJ18
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  sdc_link_if.dev          link,
  output logic      [17:0] left_sample_o,
  output logic      [17:0] right_sample_o,
  output logic             sample_valid_o,
  output logic             deemph_o,
  output logic             ext_mode_o,
  output logic      [4:0]  format_o,
  output logic             cfg_done_o,
  output logic             cfg_denied_o,
  output sdc_mratio_t      master_ratio_o
);
  // synchronisers: [0] first stage, [1] second, [2] previous
  logic [2:0]  ws_sy;
  logic [2:0]  bk_sy;
  logic [1:0]  sd_sy;
  logic        ws_s;
  logic        ws_p;
  logic        ws_fall;
  logic        ws_edge;
  logic        bk_s;
  logic        bk_rise;
  logic        bk_fall;
  logic        sd_s;
  // ratio detection
  logic [9:0]  mcnt;
  // external mode detection
  logic [2:0]  bkcnt;
  // de-emphasis filter
  logic [3:0]  dcnt;
  logic        dlast;
  // configuration shifter
  logic [7:0]  cshift;
  logic [7:0]  next_code;
  logic [2:0]  ccnt;
  // data path
  logic [4:0]  divcnt;
  logic [4:0]  div;
  logic        int_en;
  logic        smp_en;
  logic [17:0] shreg;
  logic [17:0] next_shreg;
  logic [17:0] held;
  logic [17:0] word;
  logic [6:0]  pcnt;
  logic [6:0]  last_pos;
  logic        rj;
  logic        i2s;
  logic        w16;

  // clocks per internal bit for this master ratio and format
  function automatic logic [4:0] int_div(input sdc_mratio_t mr,
                                         input logic [4:0] f);
    logic fast;
    fast = f[F_EDGE_HI] & ~f[F_EDGE_LO];
    unique case (mr)
      SDC_MR_384: int_div = 5'd8;                  // 48 Fs
      SDC_MR_256: int_div = fast ? 5'd4 : 5'd8;    // 64 or 32 Fs
      SDC_MR_512: int_div = fast ? 5'd8 : 5'd16;   // 64 or 32 Fs
      default:    int_div = 5'd8;
    endcase
  endfunction : int_div

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; only stage two and three feed logic
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      ws_sy <= 3'h0;
      bk_sy <= 3'h7; // pin idles high, so no false rise after reset
      sd_sy <= 2'h0;
    end else begin
      ws_sy <= {ws_sy[1:0], link.word_select_clock};
      bk_sy <= {bk_sy[1:0], link.emphasis_or_bitclock_pin};
      sd_sy <= {sd_sy[0], link.serial_audio_in};
    end
  end

  assign ws_s    = ws_sy[1];
  assign ws_p    = ws_sy[2];
  assign ws_fall = ws_p & ~ws_s;
  assign ws_edge = ws_p ^ ws_s;
  assign bk_s    = bk_sy[1];
  assign bk_rise = bk_s & ~bk_sy[2];
  assign bk_fall = ~bk_s & bk_sy[2];
  assign sd_s    = sd_sy[1];

  ////////////////////////////////////////////////////////////////////////////
  // master ratio: clocks counted from one word select fall to the next
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      mcnt           <= 10'h000;
      master_ratio_o <= SDC_MR_256;
    end else if (ws_fall) begin
      mcnt <= 10'h001;
      if (int'(mcnt) < MR_LIM_LO) master_ratio_o <= SDC_MR_256;
      else if (int'(mcnt) < MR_LIM_HI) master_ratio_o <= SDC_MR_384;
      else master_ratio_o <= SDC_MR_512;
    end else if (int'(mcnt) != MCNT_MAX) begin
      mcnt <= mcnt + 10'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // external mode: pin rises counted within one word select phase;
  // sticky until reset, which stands in for power-down
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      bkcnt      <= 3'h0;
      ext_mode_o <= 1'b0;
    end else begin
      if (ws_edge) bkcnt <= 3'h0;
      else if (bk_rise && bkcnt != 3'(EXT_EDGES)) bkcnt <= bkcnt + 3'h1;
      if (!ws_edge && bk_rise && bkcnt == 3'(EXT_EDGES - 1)) begin
        ext_mode_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // de-emphasis: pin level must agree on eight falls in a row
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dcnt     <= 4'h0;
      dlast    <= 1'b1;
      deemph_o <= 1'b0;
    end else if (ext_mode_o) begin
      deemph_o <= 1'b0; // filter not reachable with an outside bit clock
    end else if (ws_fall) begin
      dlast <= bk_s;
      if (bk_s != dlast) dcnt <= 4'h1;
      else if (dcnt != 4'(DEEMPH_FALLS)) dcnt <= dcnt + 4'h1;
      if (bk_s == dlast && dcnt == 4'(DEEMPH_FALLS - 1)) begin
        deemph_o <= ~bk_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration: one pin sample per word select fall while data is high
  assign next_code = {cshift[6:0], bk_s};

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cshift       <= 8'h00;
      ccnt         <= 3'h0;
      format_o     <= DEFAULT_FORMAT;
      cfg_done_o   <= 1'b0;
      cfg_denied_o <= 1'b0;
    end else begin
      cfg_done_o   <= 1'b0;
      cfg_denied_o <= 1'b0;
      if (ws_fall) begin
        if (ext_mode_o || !sd_s) begin
          // a low data line breaks the sequence; external mode locks it
          ccnt <= 3'h0;
        end else begin
          cshift <= next_code;
          ccnt   <= ccnt + 3'h1;
          if (ccnt == 3'(CFG_BITS - 1)) begin
            if (next_code[7:5] == GUARD_CODE &&
                next_code != ERROR_CODE) begin
              format_o   <= next_code[4:0];
              cfg_done_o <= 1'b1;
            end else begin
              cfg_denied_o <= 1'b1;
            end
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture enable: internal divider or an edge of the outside clock
  assign div    = int_div(master_ratio_o, format_o);
  assign int_en = !ext_mode_o && divcnt == div - 5'd1;
  assign smp_en = ext_mode_o ? (format_o[F_EDGE_LO] ? bk_fall : bk_rise)
                             : int_en;

  // a phase edge restarts the divider half a bit in, so every capture
  // lands mid-bit and the first one takes the bit sent with the edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || (int_en && !ws_edge)) begin
      divcnt <= 5'h00;
    end else if (ws_edge) begin
      divcnt <= {1'b0, div[4:1]};
    end else begin
      divcnt <= divcnt + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial word capture
  assign rj       = format_o[F_JUSTIFY];
  assign i2s      = format_o[F_I2S];
  assign w16      = format_o[F_WLEN];
  assign last_pos = (w16 ? 7'(WORD_SHORT - 1) : 7'(WORD_LONG - 1)) +
                    {6'h00, i2s};
  assign next_shreg = {shreg[16:0], sd_s};

  // right-justified words end at the phase edge, the others at a count
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      shreg <= 18'h0_0000;
      held  <= 18'h0_0000;
      pcnt  <= 7'h00;
    end else if (ws_edge) begin
      pcnt <= 7'h00;
    end else if (smp_en) begin
      shreg <= next_shreg;
      if (pcnt != 7'h7f) pcnt <= pcnt + 7'h01;
      if (!rj && pcnt == last_pos) held <= next_shreg;
    end
  end

  // word in twos complement, 16-bit words padded below the lsb
  always_comb begin
    word = rj ? shreg : held;
    if (w16) word = {word[15:0], 2'h0};
  end

  // the phase that just ended names its channel; right closes the pair
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      left_sample_o  <= 18'h0_0000;
      right_sample_o <= 18'h0_0000;
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= 1'b0;
      if (ws_edge) begin
        if (ws_p != i2s) begin
          left_sample_o <= word;
        end else begin
          right_sample_o <= word;
          sample_valid_o <= 1'b1;
        end
      end
    end
  end
endmodule : sdc_dac_port

// >>> verification/sdc_link_props.sv
`timescale 1ns/10ps
module sdc_link_props import sdc_pkg::*; (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       serial_audio_in,
  input  wire logic       word_select_clock,
  input  wire logic       emphasis_or_bitclock_pin,
  input  wire logic       sample_valid_o,
  input  wire logic       deemph_o,
  input  wire logic       ext_mode_o,
  input  wire logic [4:0] format_o,
  input  wire logic       cfg_done_o,
  input  wire logic       cfg_denied_o
);
  logic       ws_q;
  logic       pin_q;
  logic [3:0] since_fall;
  logic [3:0] since_edge;
  logic [2:0] pin_rises;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  ////////////////////////////////////////////////////////////////////////////
  // raw one-cycle copies, used only to find edges of the link wires
  always_ff @(posedge clk_i) begin
    ws_q  <= word_select_clock;
    pin_q <= emphasis_or_bitclock_pin;
  end

  // cycles since a word select fall, saturating so it never wraps
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || (ws_q && !word_select_clock)) begin
      since_fall <= 4'h0;
    end else if (since_fall != 4'hf) begin
      since_fall <= since_fall + 4'h1;
    end
  end

  // cycles since any word select edge
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || (ws_q != word_select_clock)) begin
      since_edge <= 4'h0;
    end else if (since_edge != 4'hf) begin
      since_edge <= since_edge + 4'h1;
    end
  end

  // pin rises within the current word select phase
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || (ws_q != word_select_clock)) begin
      pin_rises <= 3'h0;
    end else if (!pin_q && emphasis_or_bitclock_pin && pin_rises != 3'h7) begin
      pin_rises <= pin_rises + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_quiet;
    !sample_valid_o [*8];
  endsequence

  a_valid_once: assert property (sample_valid_o |=> s_quiet)
    else $error("sample valid pulsed twice in a short span");
  a_valid_ws: assert property (sample_valid_o |->
    since_edge <= 4'h8)
    else $error("sample valid far from a word select edge");
  a_fmt_commit: assert property ($changed(format_o) |->
    cfg_done_o || $past(cfg_done_o))
    else $error("format changed without an accepted code");
  a_done_excl: assert property (!(cfg_done_o && cfg_denied_o))
    else $error("code both accepted and denied");
  a_cfg_fall: assert property ((cfg_done_o || cfg_denied_o) |->
    since_fall <= 4'h8)
    else $error("code verdict not tied to a word select fall");
  a_cfg_sd_high: assert property ((cfg_done_o || cfg_denied_o) |->
    serial_audio_in)
    else $error("serial data low at end of configuration");
  a_ext_sticky: assert property (ext_mode_o |=> ext_mode_o)
    else $error("external clock mode left without reset");
  a_ext_entry: assert property ($rose(ext_mode_o) |->
    pin_rises >= 3'h4)
    else $error("external mode entered on too few pin rises");
  a_ext_no_cfg: assert property (ext_mode_o && $past(ext_mode_o) |->
    !cfg_done_o && !cfg_denied_o)
    else $error("configuration taken in external clock mode");
  a_deemph_int: assert property ($changed(deemph_o) |->
    !ext_mode_o && since_fall <= 4'h8)
    else $error("de-emphasis changed outside a word select fall");
endmodule : sdc_link_props

// >>> verification/testbench.sv
`timescale 1ns/10ps
module testbench import sdc_pkg::*;;
  logic        clk_i      = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic [3:0]  addr       = 4'h0;
  logic [31:0] wdata      = 32'h0000_0000;
  logic        wr         = 1'b0;
  logic        rd         = 1'b0;
  logic [31:0] rdata;
  logic [17:0] left_s;
  logic [17:0] right_s;
  logic        valid;
  logic        deemph;
  logic        ext;
  logic        done;
  logic        denied;
  logic [4:0]  fmt;
  sdc_mratio_t ratio;
  int          errors     = 0;
  int          num_checks = 0;
  int          seed       = 32'hd11bcc30;
  int          n_done     = 0;
  int          n_deny     = 0;
  int          rise_n     = 0;
  int          per_rises  = 0;
  logic        ws_d       = 1'b0;
  logic        pin_d      = 1'b1;
  logic        ext_model  = 1'b0;
  logic [4:0]  fmt_model  = FMT_RJ18;
  logic [31:0] exp_l;
  logic [31:0] exp_r;
  logic [31:0] d_v;
  logic [7:0]  codes [$];

  sdc_link_if link ();

  sdc_audio_source u_sdc_audio_source (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link(link.src), .addr_i(addr),
    .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rdata));

  sdc_dac_port #(.DEFAULT_FORMAT(FMT_RJ18)) u_sdc_dac_port (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .link(link.dev),
    .left_sample_o(left_s), .right_sample_o(right_s),
    .sample_valid_o(valid), .deemph_o(deemph), .ext_mode_o(ext),
    .format_o(fmt), .cfg_done_o(done), .cfg_denied_o(denied),
    .master_ratio_o(ratio));

  sdc_link_props u_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .serial_audio_in(link.serial_audio_in),
    .word_select_clock(link.word_select_clock),
    .emphasis_or_bitclock_pin(link.emphasis_or_bitclock_pin),
    .sample_valid_o(valid), .deemph_o(deemph), .ext_mode_o(ext),
    .format_o(fmt), .cfg_done_o(done), .cfg_denied_o(denied));

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz master clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  // verdict pulses are one cycle, so count them as they pass
  always @(posedge clk_i) begin
    if (done === 1'b1) n_done++;
    if (denied === 1'b1) n_deny++;
  end

  // pin rises per word select period, seen on the wire itself
  always @(posedge clk_i) begin
    ws_d  <= link.word_select_clock;
    pin_d <= link.emphasis_or_bitclock_pin;
    if (!pin_d && link.emphasis_or_bitclock_pin) rise_n++;
    if (!ws_d && link.word_select_clock) begin
      per_rises = rise_n;
      rise_n = 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // bounded wait for a level; running out ends the run
  task automatic wait_lv(ref logic s, input logic v, input int lim);
    for (int i = 0; i < lim; i++) begin
      @(posedge clk_i);
      #1;
      if (s === v) return;
    end
    errors++;
    $display("mismatch at %0t: wait ran out", $time);
    finish_test();
  endtask : wait_lv

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk_i);
    wr    <= 1'b0;
  endtask : wr_reg

  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk_i);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg

  // third pair after the write, so no stale word can slip through
  task automatic samples(input logic [31:0] m);
    exp_l = $random(seed) & 32'h0003_ffff;
    exp_r = $random(seed) & 32'h0003_ffff;
    wr_reg(REG_LEFT, exp_l);
    wr_reg(REG_RIGHT, exp_r);
    repeat (3) wait_lv(valid, 1'b1, 1200);
    chk(32'(left_s), exp_l & m);
    chk(32'(right_s), exp_r & m);
  endtask : samples

  task automatic cfg(input logic [7:0] c);
    logic [31:0] d;
    int          nd;
    int          nn;
    logic        ok;
    nd = n_done;
    nn = n_deny;
    ok = !ext_model && c[7:5] == GUARD_CODE && c != ERROR_CODE;
    wr_reg(REG_CODE, {24'h00_0000, c});
    rd_reg(REG_STATUS, d);
    chk(d, 32'h0000_0001);
    for (int i = 0; i < 3000 && d[0] === 1'b1; i++) rd_reg(REG_STATUS, d);
    if (d[0] !== 1'b0) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, d, 32'h0);
      finish_test();
    end
    repeat (16) @(posedge clk_i);
    #1;
    if (ok) fmt_model = c[4:0];
    chk(n_done - nd, 32'(ok));
    chk(n_deny - nn, 32'(!ok && !ext_model));
    chk(32'(fmt), 32'(fmt_model));
  endtask : cfg

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    codes = '{8'h43, 8'h40, 8'h45, 8'hd4};
    codes.push_back({3'b010, 5'($random(seed))});
    codes.push_back(8'h54);
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    #1;
    chk(32'(fmt), 32'(FMT_RJ18));
    chk(32'({ext, deemph}), 32'h0000_0000);
    rd_reg(4'hf, d_v);
    chk(d_v, 32'h0000_0000);
    wr_reg(REG_CTRL, 32'h0000_0009);
    samples(32'h0003_ffff);
    chk(32'(ratio), 32'(SDC_MR_512));
    wr_reg(REG_CTRL, 32'h0000_000d);
    wait_lv(deemph, 1'b1, 12000);
    wr_reg(REG_CTRL, 32'h0000_0009);
    wait_lv(deemph, 1'b0, 12000);
    foreach (codes[i]) cfg(codes[i]);
    cfg(8'h53);
    wr_reg(REG_CTRL, 32'h0000_0031);
    samples(32'h0003_fffc);
    wr_reg(REG_CTRL, 32'h0000_0009);
    cfg(8'h54);
    wr_reg(REG_CTRL, 32'h0000_000b);
    ext_model = 1'b1;
    wait_lv(ext, 1'b1, 2000);
    samples(32'h0003_ffff);
    chk(32'(per_rises >= 36), 32'h0000_0001);
    cfg(8'h45);
    finish_test();
  end
endmodule : testbench
